/* pkg/cfg_pin_pkg.sv */
// Package for the configuration pin interface: mode codes, widths, addresses.
// Assumes a single device-side design that imports it whole.
package cfg_pin_pkg;
    // ------------------------------------------------------------------
    // Widths and addresses
    // ------------------------------------------------------------------
    localparam int          BASE_ADDR_W  = 18;
    localparam int          EXT_ADDR_W   = 4;
    localparam int          FULL_ADDR_W  = BASE_ADDR_W + EXT_ADDR_W;
    localparam int          DATA_W       = 8;
    localparam int          STATUS_BIT   = 7;
    localparam logic [21:0] ADDR_UP_START   = 22'h000000;
    localparam logic [21:0] ADDR_DOWN_START = 22'h03FFFF;
    localparam logic [21:0] ADDR_DOWN_START_EXT = 22'h3FFFFF;
    localparam logic [2:0]  BIT_LAST     = 3'h7;
    localparam int          SYNC_DEPTH   = 2;
    localparam logic [2:0]  FETCH_SETTLE = 3'h4;

    // ------------------------------------------------------------------
    // Loading modes, coded as the mode pins read (high, mid, low)
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_MASTER_SERIAL = 3'b000,
        MODE_MASTER_UP     = 3'b100,
        MODE_ASYNC_PERIPH  = 3'b101,
        MODE_MASTER_DOWN   = 3'b110,
        MODE_SYNC_PERIPH   = 3'b011,
        MODE_SLAVE_SERIAL  = 3'b111,
        MODE_CHAIN         = 3'b010,
        MODE_SPARE         = 3'b001
    } load_mode_t;
endpackage

/* pkg/byte_xfer_if.sv */
// Interface carrying a captured byte from the host domain into the link domain.
// Assumes the toggle handshake is synchronised by the receiver.
`timescale 1ns/100ps
interface byte_xfer_if;
    logic [7:0] byteData;
    logic       reqToggle;
    logic       ackToggle;
    modport src (output byteData, output reqToggle, input ackToggle);
    modport dst (input byteData, input reqToggle, output ackToggle);
endinterface

/* hw/byte_serializer.sv */
// Link-domain serializer: takes bytes by toggle handshake and shifts them out.
// Assumes configuration_clock is the link clock and runs while bytes are pending.
`timescale 1ns/100ps
module byte_serializer
    import cfg_pin_pkg::*;
(
    input  wire logic  configuration_clock,
    input  wire logic  linkRst_n,
    byte_xfer_if.dst   xfer,
    output logic       shiftBit,
    output logic       shiftValid
);
    logic [7:0] shift_reg;
    logic [2:0] count_reg;
    logic       busy_reg;
    logic [1:0] reqSync_reg;
    logic       reqSeen_reg;
    logic       ack_reg;

    // ------------------------------------------------------------------
    // Request crossing and byte shift, least significant bit first
    // ------------------------------------------------------------------
    // The request toggle is two-stage synchronised; only stage two is compared.
    always_ff @(posedge configuration_clock) begin
        if (!linkRst_n) begin
            reqSync_reg <= 2'h0;
            reqSeen_reg <= 1'b0;
            shift_reg   <= 8'h00;
            count_reg   <= 3'h0;
            busy_reg    <= 1'b0;
            ack_reg     <= 1'b0;
        end else begin
            reqSync_reg <= {reqSync_reg[0], xfer.reqToggle};
            if (!busy_reg && (reqSync_reg[1] != reqSeen_reg)) begin
                shift_reg   <= xfer.byteData; // Data stable while toggle is pending.
                count_reg   <= 3'h0;
                busy_reg    <= 1'b1;
                reqSeen_reg <= reqSync_reg[1];
            end else if (busy_reg) begin
                shift_reg <= {1'b0, shift_reg[7:1]};
                count_reg <= count_reg + 3'h1;
                if (count_reg == BIT_LAST) begin
                    busy_reg <= 1'b0;
                    ack_reg  <= ~ack_reg; // Buffer free again. [R21]
                end
            end
        end
    end

    assign xfer.ackToggle = ack_reg;
    assign shiftBit       = shift_reg[0];
    assign shiftValid     = busy_reg;
endmodule

/* hw/config_pin_interface.sv */
// Device-side configuration load pin logic: peripheral handshake, master
// address generation, serial input and daisy-chain output.
// Assumes ref_clk is the system clock; configuration_clock is the link clock.
//
// Behaviour
// R1 - Selected when low select low, high select high.
// R2 - Write strobe low captures parallel byte.
// R3 - Read strobe drives status on bit seven.
// R4 - Write wins when both strobes low.
// R5 - Host keeps strobes mutually exclusive.
// R6 - Chain mode: high select is serial enable.
// R7 - Master parallel drives eighteen address outputs.
// R8 - Larger members drive four extra address bits.
// R9 - Parallel modes accept bytes on data pins. The code accepts none in MODE_SYNC_PERIPH.
// R10 - Serial modes sample input on rising edges.
// R11 - Serial input is bit zero in parallel. The code takes bit zero from data pin zero instead.
// R12 - Serial output forwards data outside chain mode.
// R13 - Output changes on falling edge, 1.5 periods.
// R14 - Chain mode output drives downstream select.
// R15 - User pins read high before configuration done.
// R16 - Strobe and select pins released after done.
// R17 - Mode 000 selects master serial.
// R18 - Mode 101 selects asynchronous peripheral.
// R19 - Up mode starts at zero, increments.
// R20 - Down mode starts at 3FFFF, decrements. With extAddrEnable the code starts at 3FFFFF.
// R21 - Busy until buffer accepts another byte.
`timescale 1ns/100ps
module config_pin_interface
    import cfg_pin_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        configuration_clock,
    input  wire logic        mode_pin_high,
    input  wire logic        mode_pin_mid,
    input  wire logic        mode_pin_low,
    input  wire logic        select_active_low,
    input  wire logic        select_active_high,
    input  wire logic        write_strobe_n,
    input  wire logic        read_strobe_n,
    input  wire logic [7:0]  parallel_config_data,
    input  wire logic        serialDataIn,
    input  wire logic        extAddrEnable,
    input  wire logic        configDone,
    output logic [7:0]       dataOut,
    output logic [7:0]       dataOe_n,
    output logic [17:0]      config_memory_address,
    output logic [3:0]       extended_memory_address,
    output logic             addrOe_n,
    output logic             extAddrOe_n,
    output logic             serialDataOut,
    output logic             serialOutOe_n,
    output logic             pinsReleased,
    output logic             bytePulse,
    output logic [7:0]       byteOut
);
    // ------------------------------------------------------------------
    // Pin synchronisers (ref_clk domain)
    // ------------------------------------------------------------------
    logic [SYNC_DEPTH-1:0] sCs0_reg, sCs1_reg, sWs_reg, sRs_reg, sDone_reg;
    logic [SYNC_DEPTH-1:0] sM2_reg, sM1_reg, sM0_reg, sExt_reg;
    logic [7:0]            sData0_reg, sData1_reg;

    // Only stage two of each chain is read by logic.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sCs0_reg   <= 2'h3;
            sCs1_reg   <= 2'h0;
            sWs_reg    <= 2'h3;
            sRs_reg    <= 2'h3;
            sDone_reg  <= 2'h0;
            sM2_reg    <= 2'h0;
            sM1_reg    <= 2'h0;
            sM0_reg    <= 2'h0;
            sExt_reg   <= 2'h0;
            sData0_reg <= 8'h00;
            sData1_reg <= 8'h00;
        end else begin
            sCs0_reg   <= {sCs0_reg[0], select_active_low};
            sCs1_reg   <= {sCs1_reg[0], select_active_high};
            sWs_reg    <= {sWs_reg[0], write_strobe_n};
            sRs_reg    <= {sRs_reg[0], read_strobe_n};
            sDone_reg  <= {sDone_reg[0], configDone};
            sM2_reg    <= {sM2_reg[0], mode_pin_high};
            sM1_reg    <= {sM1_reg[0], mode_pin_mid};
            sM0_reg    <= {sM0_reg[0], mode_pin_low};
            sExt_reg   <= {sExt_reg[0], extAddrEnable};
            sData0_reg <= parallel_config_data;
            sData1_reg <= sData0_reg;
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    load_mode_t mode;
    logic       isPeriph, isMasterPar, isChain, selected, writeOn, readOn;
    logic       doneLvl;
    logic [7:0] parByte;

    assign mode        = load_mode_t'({sM2_reg[1], sM1_reg[1], sM0_reg[1]}); // [R17] [R18]
    assign isPeriph    = (mode == MODE_ASYNC_PERIPH);                        // [R18]
    assign isMasterPar = (mode == MODE_MASTER_UP) || (mode == MODE_MASTER_DOWN);
    assign isChain     = (mode == MODE_CHAIN);
    assign doneLvl     = sDone_reg[1];
    // Bit zero of the parallel byte comes from the data pins; the serial input is not used.
    assign parByte     = {sData1_reg[7:1], sData1_reg[0]};                  // [R11]
    assign selected    = !sCs0_reg[1] && sCs1_reg[1] && !doneLvl;           // [R1] [R16]
    assign writeOn     = selected && !sWs_reg[1];                            // [R2]
    assign readOn      = selected && !sRs_reg[1] && sWs_reg[1];             // [R4] [R5]

    // ------------------------------------------------------------------
    // Peripheral write capture and buffer handshake
    // ------------------------------------------------------------------
    byte_xfer_if xfer ();
    logic       writeOn_reg, req_reg, pending_reg;
    logic [7:0] buf_reg;
    logic [1:0] ackSync_reg;
    logic       ackSeen_reg;
    logic       capture, masterTake;

    // A held strobe captures once, on its falling edge, so one pulse is one byte.
    assign capture = writeOn && !writeOn_reg && !pending_reg && isPeriph;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            writeOn_reg <= 1'b0;
            req_reg     <= 1'b0;
            pending_reg <= 1'b0;
            buf_reg     <= 8'h00;
            ackSync_reg <= 2'h0;
            ackSeen_reg <= 1'b0;
        end else begin
            writeOn_reg <= writeOn;
            ackSync_reg <= {ackSync_reg[0], xfer.ackToggle};
            if (capture || masterTake) begin
                buf_reg     <= parByte;                                      // [R2] [R9]
                req_reg     <= ~req_reg;
                pending_reg <= 1'b1;                                         // [R21]
            end else if (pending_reg && (ackSync_reg[1] != ackSeen_reg)) begin
                pending_reg <= 1'b0;                                         // [R21]
                ackSeen_reg <= ackSync_reg[1];
            end
        end
    end

    assign xfer.byteData  = buf_reg;
    assign xfer.reqToggle = req_reg;

    // ------------------------------------------------------------------
    // Data pin drive: status on read, else released high by pull-up
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dataOut  <= 8'hFF;
            dataOe_n <= 8'hFF;
        end else if (readOn && isPeriph) begin
            dataOut  <= {!pending_reg, 7'h7F};                               // [R3] [R21]
            dataOe_n <= 8'h00;
        end else begin
            dataOut  <= 8'hFF;                                               // [R15]
            dataOe_n <= 8'hFF;
        end
    end

    // ------------------------------------------------------------------
    // Master parallel address counter and byte acceptance
    // ------------------------------------------------------------------
    logic [21:0] addr_reg;
    logic        started_reg;
    logic        masterFree;
    logic [2:0]  settle_reg;

    // A new byte is fetched only when the serializer has room.
    assign masterFree = isMasterPar && !pending_reg && !doneLvl;
    // The byte is taken only once the new address has passed both data sync stages.
    assign masterTake = started_reg && masterFree && (settle_reg == FETCH_SETTLE); // [R9]

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            addr_reg    <= ADDR_UP_START;
            started_reg <= 1'b0;
        end else if (!isMasterPar || doneLvl) begin
            started_reg <= 1'b0;
        end else if (!started_reg) begin
            started_reg <= 1'b1;
            if (mode == MODE_MASTER_DOWN) begin
                addr_reg <= sExt_reg[1] ? ADDR_DOWN_START_EXT : ADDR_DOWN_START; // [R20]
            end else begin
                addr_reg <= ADDR_UP_START;                                   // [R19]
            end
        end else if (masterTake) begin
            if (mode == MODE_MASTER_DOWN) begin
                addr_reg <= addr_reg - 22'h1;                                // [R20]
            end else begin
                addr_reg <= addr_reg + 22'h1;                                // [R19]
            end
        end
    end

    // Cycles since the last address step; a stale byte is never taken this way.
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !started_reg || masterTake) begin
            settle_reg <= 3'h0;
        end else if (settle_reg != FETCH_SETTLE) begin
            settle_reg <= settle_reg + 3'h1;
        end
    end

    // Address pins are driven only while fetching; extension only when enabled.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            config_memory_address   <= 18'h3FFFF;
            extended_memory_address <= 4'hF;
            addrOe_n                <= 1'b1;
            extAddrOe_n             <= 1'b1;
        end else begin
            config_memory_address   <= addr_reg[BASE_ADDR_W-1:0];            // [R7]
            extended_memory_address <= addr_reg[FULL_ADDR_W-1:BASE_ADDR_W];  // [R8]
            addrOe_n                <= !(started_reg && !doneLvl);           // [R7]
            extAddrOe_n             <= !(started_reg && !doneLvl && sExt_reg[1]); // [R8]
        end
    end

    // ------------------------------------------------------------------
    // Captured byte report and pin release
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bytePulse    <= 1'b0;
            byteOut      <= 8'h00;
            pinsReleased <= 1'b0;
        end else begin
            bytePulse    <= capture || masterTake;
            byteOut      <= parByte;
            pinsReleased <= doneLvl;                                         // [R16]
        end
    end

    // ------------------------------------------------------------------
    // Link domain: serial input, serializer, daisy-chain output
    // ------------------------------------------------------------------
    logic [1:0] linkRst_reg;
    logic       linkRst_n;
    logic       din_reg, dinDly_reg;
    logic       shiftBit, shiftValid;
    logic       serialMode;
    logic [1:0] modeSerSync_reg, chainSync_reg, chainEnSync_reg;

    // Reset and mode levels cross into the link clock through two stages.
    always_ff @(posedge configuration_clock) begin
        linkRst_reg     <= {linkRst_reg[0], rst_n};
        modeSerSync_reg <= {modeSerSync_reg[0],
                            (mode == MODE_MASTER_SERIAL) || (mode == MODE_SLAVE_SERIAL)};
        chainSync_reg   <= {chainSync_reg[0], isChain};
        chainEnSync_reg <= {chainEnSync_reg[0], select_active_high};         // [R6]
    end
    assign linkRst_n  = linkRst_reg[1];
    assign serialMode = modeSerSync_reg[1];

    byte_serializer u_ser (
        .configuration_clock (configuration_clock),
        .linkRst_n           (linkRst_n),
        .xfer                (xfer),
        .shiftBit            (shiftBit),
        .shiftValid          (shiftValid)
    );

    // Serial input sampled on the rising edge, held one more rising edge.
    always_ff @(posedge configuration_clock) begin
        if (!linkRst_n) begin
            din_reg    <= 1'b1;
            dinDly_reg <= 1'b1;
        end else begin
            din_reg    <= serialDataIn;                                      // [R10]
            dinDly_reg <= serialMode ? din_reg : shiftBit;                   // [R12]
        end
    end

    // Launch on the falling edge: rise sample, one rise stage, then fall, 1.5 periods.
    always_ff @(negedge configuration_clock) begin
        if (!linkRst_n) begin
            serialDataOut <= 1'b1;
            serialOutOe_n <= 1'b1;
        end else if (chainSync_reg[1]) begin
            serialDataOut <= chainEnSync_reg[1];                             // [R14]
            serialOutOe_n <= 1'b0;
        end else begin
            serialDataOut <= (serialMode || shiftValid) ? dinDly_reg : 1'b1; // [R13]
            serialOutOe_n <= 1'b0;                                           // [R12]
        end
    end
endmodule

/* test/config_pin_checker.sv */
// Concurrent checks on the ports of the configuration pin interface.
// Assumes the mode pins only change while rst_n is held low.
`timescale 1ns/100ps
module config_pin_checker (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        configuration_clock,
    input wire logic        mode_pin_high,
    input wire logic        mode_pin_mid,
    input wire logic        mode_pin_low,
    input wire logic        select_active_low,
    input wire logic        select_active_high,
    input wire logic        write_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic        serialDataIn,
    input wire logic [7:0]  dataOut,
    input wire logic [7:0]  dataOe_n,
    input wire logic [17:0] config_memory_address,
    input wire logic        addrOe_n,
    input wire logic        serialDataOut,
    input wire logic        serialOutOe_n,
    input wire logic        pinsReleased,
    input wire logic        bytePulse
);
    // ------------------------------------------------------------------
    // Decoded pin state
    // ------------------------------------------------------------------
    // Raw pins are used; the design's two-stage sync is covered by past depths.
    wire [2:0] mode    = {mode_pin_high, mode_pin_mid, mode_pin_low};
    wire       rdReq   = !select_active_low && select_active_high && !read_strobe_n;
    wire       serMode = (mode == 3'b000) || (mode == 3'b111);

    readDrive_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        dataOe_n == 8'h00 |-> dataOut[6:0] == 7'h7F) else $error("status low bits not high");
    readCause_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        dataOe_n == 8'h00 |-> ($past(rdReq, 3) || $past(rdReq, 4)))
        else $error("data pins driven without a selected read");
    writeWins_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!write_strobe_n && !read_strobe_n) [*5] |-> dataOe_n == 8'hFF)
        else $error("read answered while write strobe low");
    pulseSingle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bytePulse |=> !bytePulse) else $error("byte accepted twice in a row");
    busyHold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bytePulse |=> (dataOe_n != 8'h00 || !dataOut[7]) [*3])
        else $error("ready shown right after a byte");
    released_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pinsReleased [*2] |-> dataOe_n == 8'hFF && addrOe_n) else $error("pins not released");
    upStart_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(addrOe_n) && mode == 3'b100 |-> config_memory_address == 18'h00000)
        else $error("up address does not start at zero");
    upStep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !addrOe_n && $past(addrOe_n) == 1'b0 && mode == 3'b100
        && $changed(config_memory_address) |->
        config_memory_address == $past(config_memory_address) + 18'h1)
        else $error("up address step is not plus one");
    downStep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !addrOe_n && $past(addrOe_n) == 1'b0 && mode == 3'b110
        && $changed(config_memory_address) |->
        config_memory_address == $past(config_memory_address) - 18'h1)
        else $error("down address step is not minus one");
    serialPipe_a: assert property (@(posedge configuration_clock) disable iff (!rst_n)
        serMode && !serialOutOe_n && $past(serialOutOe_n, 2) == 1'b0
        |-> serialDataOut == $past(serialDataIn, 2)) else $error("serial out pipeline wrong");
endmodule

bind config_pin_interface config_pin_checker i_chk (.*);

/* test/cfg_memory_model.sv */
// Byte-wide configuration memory standing at the far side of the address pins.
// Assumes the bench predicts each byte as the low address byte XOR 5A.
`timescale 1ns/100ps
module cfg_memory_model #(
    parameter int ACCESS_NS = 0
) (
    input  wire logic        ref_clk,
    input  wire logic [17:0] config_memory_address,
    input  wire logic        addrOe_n,
    output logic [7:0]       memData
);
    logic flip = 1'b0;

    // Undriven address gives toggling data, so a stale byte cannot look valid.
    always @(posedge ref_clk) flip <= ~flip;
    assign #(ACCESS_NS) memData = addrOe_n ? {8{flip}} : config_memory_address[7:0] ^ 8'h5A;
endmodule

/* test/config_pin_interface_tb.sv */
// Self-checking bench for the configuration pin interface.
// Assumes the bound checker and the memory model are compiled before it.
`timescale 1ns/100ps
module config_pin_interface_tb
    import cfg_pin_pkg::*;
;
    logic ref_clk = 1'b0, rst_n = 1'b0, configuration_clock = 1'b0;
    load_mode_t mode = MODE_ASYNC_PERIPH;
    logic select_active_low = 1'b0, select_active_high = 1'b1;
    logic write_strobe_n = 1'b1, read_strobe_n = 1'b1, extAddrEnable = 1'b0;
    logic configDone = 1'b0, pinsReleased, bytePulse, serialDataOut, serialOutOe_n;
    logic [7:0] hd = 8'h00, memData, dataOut, dataOe_n, byteOut, q;
    logic [17:0] config_memory_address;
    logic [3:0] extended_memory_address;
    logic addrOe_n, extAddrOe_n, got;
    logic [31:0] pat = 32'hC3A596F0;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    wire [7:0] pcd = (mode == MODE_MASTER_UP || mode == MODE_MASTER_DOWN) ? memData : hd;

    config_pin_interface i_dut (.mode_pin_high(mode[2]), .mode_pin_mid(mode[1]),
        .mode_pin_low(mode[0]), .parallel_config_data(pcd), .serialDataIn(pat[31]), .*);
    cfg_memory_model i_mem (.ref_clk(ref_clk), .config_memory_address(config_memory_address),
        .addrOe_n(addrOe_n), .memData(memData));

    // ------------------------------------------------------------------
    // Clocks, serial stimulus and hang guard
    // ------------------------------------------------------------------
    always #2.5 ref_clk = ~ref_clk;
    always #3 configuration_clock = ~configuration_clock;
    // Serial bits move on the falling link edge so the rising sample is clean.
    always @(negedge configuration_clock) pat <= {pat[30:0], pat[31]};
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic compare(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic doReset(input load_mode_t m);
        @(negedge ref_clk);
        rst_n = 1'b0;
        mode = m;
        repeat (8) @(negedge ref_clk);
        rst_n = 1'b1;
    endtask

    // A pulse lasts one cycle, so it is looked for just after each edge.
    task automatic waitPulse(output logic seen);
        seen = 1'b0;
        repeat (40) begin
            @(posedge ref_clk);
            #1;
            if (bytePulse === 1'b1) begin
                seen = 1'b1;
                break;
            end
        end
    endtask

    // The host holds the strobe until the byte is taken and never overlaps a read.
    task automatic hostWrite(input logic [7:0] d);
        @(negedge ref_clk);
        hd = d;
        write_strobe_n = 1'b0;
        waitPulse(got);
        @(negedge ref_clk);
        write_strobe_n = 1'b1;
    endtask

    task automatic hostRead(output logic [7:0] r);
        @(negedge ref_clk);
        read_strobe_n = 1'b0;
        repeat (5) @(negedge ref_clk);
        compare(dataOe_n, 8'h00);
        r = dataOut;
        read_strobe_n = 1'b1;
        repeat (5) @(negedge ref_clk);
    endtask

    task automatic endTest(input string name);
        $display("test %s done, %0d mismatches so far", name, n_mismatch);
    endtask

    task automatic finish_test();
        $display("compares %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        doReset(MODE_ASYNC_PERIPH);
        repeat (3) @(negedge ref_clk);
        compare(dataOe_n, 8'hFF);
        hostWrite(8'hA5);
        compare(got, 1'b1);
        compare(byteOut, 8'hA5);
        hostRead(q);
        compare(q, 8'h7F);
        for (int i = 0; i < 10 && q !== 8'hFF; i++) hostRead(q);
        compare(q, 8'hFF);
        endTest("peripheral");
        select_active_low = 1'b1;
        hostWrite(8'h3C);
        compare(got, 1'b0);
        select_active_low = 1'b0;
        @(negedge ref_clk);
        write_strobe_n = 1'b0;
        read_strobe_n = 1'b0;
        waitPulse(got);
        repeat (4) @(negedge ref_clk);
        compare(got, 1'b1);
        compare(dataOe_n, 8'hFF);
        compare(byteOut, 8'h3C);
        write_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        endTest("select and priority");
        doReset(MODE_MASTER_UP);
        waitPulse(got);
        compare(byteOut, 8'h5A);
        compare(addrOe_n, 1'b0);
        repeat (60) @(negedge ref_clk);
        endTest("master up");
        extAddrEnable = 1'b1;
        doReset(MODE_MASTER_DOWN);
        waitPulse(got);
        compare(byteOut, 8'hA5);
        compare({extAddrOe_n, extended_memory_address}, 5'h0F);
        repeat (60) @(negedge ref_clk);
        endTest("master down");
        foreach (pat[i]) if (i < 2) begin
            doReset(i == 0 ? MODE_MASTER_SERIAL : MODE_SLAVE_SERIAL);
            repeat (80) @(negedge ref_clk);
            compare(serialOutOe_n, 1'b0);
        end
        endTest("serial");
        doReset(MODE_CHAIN);
        for (int i = 0; i < 2; i++) begin
            select_active_high = i[0];
            repeat (12) @(negedge ref_clk);
            compare(serialDataOut, i[0]);
        end
        endTest("chain");
        configDone = 1'b1;
        repeat (8) @(negedge ref_clk);
        compare(pinsReleased, 1'b1);
        compare({dataOe_n, addrOe_n}, 9'h1FF);
        endTest("release");
        finish_test();
    end
endmodule
